// [verilog/abu_top.sv]
// address breakpoint unit top: control registers, break request to the
// cpu, wake flag and clear gating for status flags elsewhere.
// assumes the cpu sequencer, its wait/stop state and the other status
// registers are logic on the same aclk.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none

module abu_top
   import abu_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [ABU_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ABU_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire abu_cpu_bus_t          cpu,
   input  wire logic                  cpu_in_break,
   input  wire logic                  cpu_low_power,
   output logic                       break_request,
   output logic                       break_immediate,
   output logic                       status_clear_allow
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      abu_regs_t regs;
      logic      req;
      logic      imm;
      logic      allow;
   } abu_state_t;

   abu_state_t st, next_st;

   logic                  hit;
   logic                  wr_fire;
   logic [ABU_ADDR_W-1:0] wr_addr;
   logic [7:0]            wr_byte;
   logic [ABU_ADDR_W-1:0] read_addr;
   logic [31:0]           read_word;

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   abu_regs abu_regs_inst (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (s_axi_awaddr),
      .awvalid   (s_axi_awvalid),
      .awready   (s_axi_awready),
      .wdata     (s_axi_wdata),
      .wstrb     (s_axi_wstrb),
      .wvalid    (s_axi_wvalid),
      .wready    (s_axi_wready),
      .bresp     (s_axi_bresp),
      .bvalid    (s_axi_bvalid),
      .bready    (s_axi_bready),
      .araddr    (s_axi_araddr),
      .arvalid   (s_axi_arvalid),
      .arready   (s_axi_arready),
      .rdata     (s_axi_rdata),
      .rresp     (s_axi_rresp),
      .rvalid    (s_axi_rvalid),
      .rready    (s_axi_rready),
      .read_word (read_word),
      .read_addr (read_addr),
      .wr_fire   (wr_fire),
      .wr_addr   (wr_addr),
      .wr_byte   (wr_byte)
   );

   abu_match abu_match_inst (
      .enable       (st.regs.break_enable_bit),
      .address_high (st.regs.address_high),
      .address_low  (st.regs.address_low),
      .cpu          (cpu),
      .hit          (hit)
   );

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   always_comb begin
      read_word = 32'h0000_0000;
      unique case (read_addr)
         ABU_OFS_CTRL: begin
            read_word[ABU_BIT_ENABLE] = st.regs.break_enable_bit;
            read_word[ABU_BIT_ACTIVE] = st.regs.break_active_bit;
         end
         ABU_OFS_ADDR_HI: read_word[7:0] = st.regs.address_high;
         ABU_OFS_ADDR_LO: read_word[7:0] = st.regs.address_low;
         ABU_OFS_WAKE:    read_word[ABU_BIT_WAKE] = st.regs.break_wake_flag;
         ABU_OFS_FLAGCLR: read_word[ABU_BIT_CLREN] = st.regs.clear_during_break_enable;
         default:         read_word = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st     = st;
      next_st.req = 1'b0;
      next_st.imm = 1'b0;
      if (wr_fire) begin
         unique case (wr_addr)
            ABU_OFS_CTRL: begin
               next_st.regs.break_enable_bit = wr_byte[ABU_BIT_ENABLE];
               next_st.regs.break_active_bit = wr_byte[ABU_BIT_ACTIVE];
               // software trigger, no address match needed
               next_st.req = wr_byte[ABU_BIT_ACTIVE];
            end
            ABU_OFS_ADDR_HI: next_st.regs.address_high = wr_byte;
            ABU_OFS_ADDR_LO: next_st.regs.address_low  = wr_byte;
            ABU_OFS_WAKE: begin
               // only a zero clears, a one is ignored
               if (!wr_byte[ABU_BIT_WAKE]) begin
                  next_st.regs.break_wake_flag = 1'b0;
               end
            end
            ABU_OFS_FLAGCLR: next_st.regs.clear_during_break_enable = wr_byte[ABU_BIT_CLREN];
            default: next_st.regs = st.regs;
         endcase
      end
      // set wins over a same-cycle software clear
      if (hit) begin
         next_st.regs.break_active_bit = 1'b1;
         next_st.req = 1'b1;
         // match on final instruction cycle: cpu takes the break at once
         next_st.imm = cpu.last_cycle;
      end
      if (next_st.req && cpu_low_power) begin
         next_st.regs.break_wake_flag = 1'b1;
      end
      // outside break, clears always allowed
      next_st.allow = !cpu_in_break || next_st.regs.clear_during_break_enable;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '{regs: '{address_high: ABU_RST_BYTE, address_low: ABU_RST_BYTE, default: 1'b0},
                 allow: 1'b1, default: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign break_request      = st.req;
   assign break_immediate    = st.imm;
   assign status_clear_allow = st.allow;
endmodule : abu_top

`default_nettype wire

// [verilog/abu_pkg.sv]
// package for the address breakpoint unit: register map, bit positions,
// reset values and carrier structs.
// assumes a 32-bit AXI4-Lite register bus and a 16-bit cpu address bus.
`default_nettype none

package abu_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ABU_OFS_CTRL    = 8'h00;
   localparam logic [7:0] ABU_OFS_ADDR_HI = 8'h04;
   localparam logic [7:0] ABU_OFS_ADDR_LO = 8'h08;
   localparam logic [7:0] ABU_OFS_WAKE    = 8'h0C;
   localparam logic [7:0] ABU_OFS_FLAGCLR = 8'h10;
   localparam int         ABU_ADDR_W      = 8;

   // ---------------------------------------------------------------
   // bit positions and reset values
   // ---------------------------------------------------------------
   localparam int         ABU_BIT_ENABLE  = 7;
   localparam int         ABU_BIT_ACTIVE  = 6;
   localparam int         ABU_BIT_WAKE    = 1;
   localparam int         ABU_BIT_CLREN   = 7;
   localparam logic [7:0] ABU_RST_BYTE    = 8'h00;
   localparam logic [1:0] ABU_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ABU_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        fetch;
      logic        last_cycle;
      logic [15:0] addr;
   } abu_cpu_bus_t;

   typedef struct packed {
      logic break_enable_bit;
      logic break_active_bit;
      logic break_wake_flag;
      logic clear_during_break_enable;
      logic [7:0] address_high;
      logic [7:0] address_low;
   } abu_regs_t;

endpackage : abu_pkg

`default_nettype wire

// [verilog/abu_match.sv]
// address comparator for the address breakpoint unit.
// assumes cpu address and qualifiers arrive on aclk from cpu logic.
`default_nettype none

module abu_match
   import abu_pkg::*;
(
   input  wire logic         enable,
   input  wire logic [7:0]   address_high,
   input  wire logic [7:0]   address_low,
   input  wire abu_cpu_bus_t cpu,
   output logic              hit
);
   // only program counter fetches count, other masters' data accesses ignored
   assign hit = enable && cpu.fetch && (cpu.addr == {address_high, address_low});
endmodule : abu_match

`default_nettype wire

// [verilog/abu_regs.sv]
// AXI4-Lite slave front end: registers one write and one read at a time.
// assumes a single aclk domain; unmapped addresses answer SLVERR.
`default_nettype none

module abu_regs
   import abu_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [ABU_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [ABU_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire logic [31:0]           read_word,
   output logic [ABU_ADDR_W-1:0]      read_addr,
   output logic                       wr_fire,
   output logic [ABU_ADDR_W-1:0]      wr_addr,
   output logic [7:0]                 wr_byte
);
   typedef struct packed {
      logic                  aw_held;
      logic                  w_held;
      logic [ABU_ADDR_W-1:0] awaddr;
      logic [7:0]            wbyte;
      logic                  wlane;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
      logic                  fire;
      logic                  awrdy;
      logic                  wrdy;
      logic                  arrdy;
   } abu_bus_state_t;

   abu_bus_state_t st, next_st;

   function automatic logic abu_mapped(input logic [ABU_ADDR_W-1:0] a);
      abu_mapped = (a == ABU_OFS_CTRL) || (a == ABU_OFS_ADDR_HI) || (a == ABU_OFS_ADDR_LO)
                   || (a == ABU_OFS_WAKE) || (a == ABU_OFS_FLAGCLR);
   endfunction : abu_mapped

   // readies kept in flops so every bus output of the top is registered
   assign awready   = st.awrdy;
   assign wready    = st.wrdy;
   assign arready   = st.arrdy;
   assign bvalid    = st.bvalid;
   assign bresp     = st.bresp;
   assign rvalid    = st.rvalid;
   assign rresp     = st.rresp;
   assign rdata     = st.rdata;
   assign read_addr = araddr;
   assign wr_fire   = st.fire;
   assign wr_addr   = st.awaddr;
   assign wr_byte   = st.wbyte;

   always_comb begin
      next_st      = st;
      next_st.fire = 1'b0;
      if (awvalid && awready) begin
         next_st.aw_held = 1'b1;
         next_st.awaddr  = awaddr;
      end
      if (wvalid && wready) begin
         next_st.w_held = 1'b1;
         next_st.wbyte  = wdata[7:0];
         next_st.wlane  = wstrb[0];
      end
      // response only once both address and data are held
      if (st.aw_held && st.w_held) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = abu_mapped(st.awaddr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
         next_st.fire    = abu_mapped(st.awaddr) && st.wlane;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = abu_mapped(araddr) ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
         next_st.rdata  = abu_mapped(araddr) ? read_word : 32'h0000_0000;
      end else if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      next_st.awrdy = !next_st.aw_held && !next_st.bvalid;
      next_st.wrdy  = !next_st.w_held && !next_st.bvalid;
      next_st.arrdy = !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end
endmodule : abu_regs

`default_nettype wire

// [sim/abu_properties.sv]
// port checker for the address breakpoint unit top.
// assumes it is bound onto abu_top; single aclk domain.
`default_nettype none

module abu_properties
   import abu_pkg::*;
(
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic         s_axi_bvalid,
   input wire logic         s_axi_bready,
   input wire logic         s_axi_arvalid,
   input wire logic         s_axi_arready,
   input wire logic         s_axi_rvalid,
   input wire logic         s_axi_rready,
   input wire abu_cpu_bus_t cpu,
   input wire logic         cpu_in_break,
   input wire logic         break_request,
   input wire logic         break_immediate,
   input wire logic         status_clear_allow
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----
   // assertions
   // ----
   a_req_cause: assert property (break_request |-> $past(cpu.fetch) || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("break request without fetch or write");
   a_imm_with_req: assert property (break_immediate |-> break_request)
      else $error("immediate break without request");
   a_imm_last: assert property (break_immediate |-> $past(cpu.last_cycle) && $past(cpu.fetch))
      else $error("immediate break not on last cycle");
   a_imm_taken: assert property ($past(cpu.last_cycle) && break_request |-> break_immediate)
      else $error("last cycle match not immediate");
   a_clear_free: assert property (!cpu_in_break |=> status_clear_allow)
      else $error("clear blocked outside break");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered in two cycles");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   c_immediate: cover property (break_immediate);
   c_gated: cover property (!status_clear_allow);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : abu_properties

`default_nettype wire

// [sim/abu_cpu_model.sv]
// cpu core model: drives fetch addresses, enters break on request.
// assumes the bench commands each fetch one cycle ahead.
`default_nettype none

module abu_cpu_model
   import abu_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        break_request,
   input  wire logic [15:0] go_addr,
   input  wire logic        go_fetch,
   input  wire logic        go_last,
   input  wire logic        go_sleep,
   input  wire logic        go_resume,
   output var abu_cpu_bus_t cpu,
   output logic             cpu_in_break,
   output logic             cpu_low_power
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge aclk) begin
      cpu <= '{fetch: go_fetch, last_cycle: go_last, addr: go_addr};
      // break taken at once, left only on return
      cpu_in_break <= aresetn & (break_request | (cpu_in_break & !go_resume));
      cpu_low_power <= aresetn & go_sleep & !break_request;
   end
endmodule : abu_cpu_model

`default_nettype wire

// [sim/test_address_breakpoint_unit.sv]
// bench for the address breakpoint unit over AXI4-Lite and a cpu model.
// assumes abu_pkg, abu_top, abu_cpu_model and abu_properties compiled.
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_address_breakpoint_unit;
   import abu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
   logic [7:0]   awa = 8'h00, ara = 8'h00;
   logic [3:0]   ws = 4'hF;
   logic [31:0]  wd = 32'h0, rdat;
   logic [15:0]  g_addr = 16'h0;
   logic         g_fetch = 1'h0, g_last = 1'h0, g_sleep = 1'h0, g_res = 1'h0;
   logic         awr, wrd, bv, arr, rv, req, imm, allow, inbrk, lowp;
   logic [1:0]   br, rr;
   abu_cpu_bus_t cpu;
   int           bad_count = 0, total_checks = 0, reqs = 0, imms = 0;

   abu_top abu_top_inst(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .cpu(cpu), .cpu_in_break(inbrk), .cpu_low_power(lowp), .break_request(req),
      .break_immediate(imm), .status_clear_allow(allow));
   abu_cpu_model abu_cpu_model_inst(.aclk(aclk), .aresetn(aresetn), .break_request(req), .go_addr(g_addr),
      .go_fetch(g_fetch), .go_last(g_last), .go_sleep(g_sleep), .go_resume(g_res), .cpu(cpu),
      .cpu_in_break(inbrk), .cpu_low_power(lowp));

   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) begin
      reqs <= reqs + int'(req === 1'h1);
      imms <= imms + int'(imm === 1'h1);
   end
   // ----
   // bus and cpu tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awa <= a; wd <= {24'h0, d}; awv <= 1'h1; wv <= 1'h1; bre <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (awv && awr) awv <= 1'h0;
         if (wv && wrd) wv <= 1'h0;
      end while (bv !== 1'h1 && n < 50);
      `CHK(bv, 1'h1)
      `CHK(br, er)
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      ara <= a; arv <= 1'h1; rre <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (arv && arr) arv <= 1'h0;
      end while (rv !== 1'h1 && n < 50);
      `CHK(rv, 1'h1)
      `CHK(rdat, ed)
      `CHK(rr, er)
   endtask : rd
   task automatic fetch(input logic [15:0] a, input logic f, input logic l, input int er, input int ei);
      int r0, i0;
      r0 = reqs;
      i0 = imms;
      g_addr <= a; g_fetch <= f; g_last <= l;
      @(posedge aclk);
      g_addr <= ~a; g_fetch <= 1'h0; g_last <= 1'h0;
      repeat (4) @(posedge aclk);
      `CHK(reqs - r0, er)
      `CHK(imms - i0, ei)
   endtask : fetch
   task automatic resume();
      g_res <= 1'h1;
      @(posedge aclk);
      g_res <= 1'h0;
   endtask : resume
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, ABU_RESP_OKAY);
      rd(8'h14, 32'h0, ABU_RESP_SLVERR);
      wr(8'h14, 8'hFF, ABU_RESP_SLVERR);
      // low byte lane off: write answered but ignored
      ws <= 4'hE;
      wr(ABU_OFS_ADDR_HI, 8'hAA, ABU_RESP_OKAY);
      ws <= 4'hF;
      rd(ABU_OFS_ADDR_HI, 32'h0, ABU_RESP_OKAY);
      rd(ABU_OFS_CTRL, 32'h0, ABU_RESP_OKAY);
      `CHK(allow, 1'h1)
      $display("test reset done");
   endtask : t_reset
   task automatic t_match();
      wr(ABU_OFS_ADDR_HI, 8'h12, ABU_RESP_OKAY);
      wr(ABU_OFS_ADDR_LO, 8'h34, ABU_RESP_OKAY);
      fetch(16'h1234, 1'h1, 1'h0, 0, 0);
      wr(ABU_OFS_CTRL, 8'h80, ABU_RESP_OKAY);
      rd(ABU_OFS_CTRL, 32'h80, ABU_RESP_OKAY);
      fetch(16'h1235, 1'h1, 1'h0, 0, 0);
      fetch(16'h1234, 1'h0, 1'h0, 0, 0);
      fetch(16'h1234, 1'h1, 1'h0, 1, 0);
      fetch(16'h1234, 1'h1, 1'h1, 1, 1);
      rd(ABU_OFS_CTRL, 32'hC0, ABU_RESP_OKAY);
      `CHK(allow, 1'h0)
      wr(ABU_OFS_FLAGCLR, 8'h80, ABU_RESP_OKAY);
      rd(ABU_OFS_FLAGCLR, 32'h80, ABU_RESP_OKAY);
      `CHK(allow, 1'h1)
      wr(ABU_OFS_CTRL, 8'h80, ABU_RESP_OKAY);
      rd(ABU_OFS_CTRL, 32'h80, ABU_RESP_OKAY);
      resume();
      $display("test match done");
   endtask : t_match
   task automatic t_soft();
      int r0;
      wr(ABU_OFS_CTRL, 8'h00, ABU_RESP_OKAY);
      fetch(16'h1234, 1'h1, 1'h0, 0, 0);
      r0 = reqs;
      wr(ABU_OFS_CTRL, 8'h40, ABU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(reqs - r0, 1)
      rd(ABU_OFS_CTRL, 32'h40, ABU_RESP_OKAY);
      rd(ABU_OFS_WAKE, 32'h0, ABU_RESP_OKAY);
      wr(ABU_OFS_CTRL, 8'h00, ABU_RESP_OKAY);
      rd(ABU_OFS_CTRL, 32'h0, ABU_RESP_OKAY);
      resume();
      $display("test soft done");
   endtask : t_soft
   task automatic t_wake();
      g_sleep <= 1'h1;
      repeat (2) @(posedge aclk);
      wr(ABU_OFS_CTRL, 8'h40, ABU_RESP_OKAY);
      g_sleep <= 1'h0;
      rd(ABU_OFS_WAKE, 32'h2, ABU_RESP_OKAY);
      wr(ABU_OFS_WAKE, 8'h00, ABU_RESP_OKAY);
      rd(ABU_OFS_WAKE, 32'h0, ABU_RESP_OKAY);
      wr(ABU_OFS_WAKE, 8'h02, ABU_RESP_OKAY);
      rd(ABU_OFS_WAKE, 32'h0, ABU_RESP_OKAY);
      $display("test wake done");
   endtask : t_wake
   task automatic t_rerst();
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ABU_OFS_CTRL, 32'h0, ABU_RESP_OKAY);
      rd(ABU_OFS_ADDR_HI, 32'h0, ABU_RESP_OKAY);
      rd(ABU_OFS_ADDR_LO, 32'h0, ABU_RESP_OKAY);
      rd(ABU_OFS_FLAGCLR, 32'h0, ABU_RESP_OKAY);
      `CHK(allow, 1'h1)
      $display("test mid reset done");
   endtask : t_rerst
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_match();
      t_soft();
      t_wake();
      t_rerst();
      final_report();
   end
   // whole run is under 1000 cycles
   initial begin
      #50000;
      bad_count++;
      final_report();
   end
endmodule : test_address_breakpoint_unit

bind abu_top abu_properties abu_properties_inst(.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .cpu, .cpu_in_break, .break_request, .break_immediate, .status_clear_allow);

`default_nettype wire
